//--- logic/add_exec_defines.vh
// Constants for the add execution datapath: opcodes, register file layout,
// bus offsets, status field positions and reset values.
// Assumes plain Verilog-2005 and inclusion by bare name.
`ifndef ADD_EXEC_DEFINES_VH
`define ADD_EXEC_DEFINES_VH

// ****************************************************************
// Opcodes
// ****************************************************************
`define OPC_ADD_WORD        8'h40
`define OPC_ADD_HALF        8'h41
`define OPC_ADD_FLOAT_WORD  8'h42
`define OPC_ADD_FLOAT_DBL   8'h43
`define OPC_ADD_MAG_WORD    8'h44
`define OPC_ADD_MAG_HALF    8'h45
`define OPC_ADD_MAG_FLOAT   8'h46
`define OPC_ADD_IMM_WORD    8'h50
`define OPC_ADD_IMM_HALF    8'h51
`define OPC_ADD_BASE        8'h60
`define OPC_ADD_IDXVEC      8'h62
`define OPC_ADD_IMM_BASE    8'h70
`define OPC_ADD_IMM_IDXVEC  8'h72

// ****************************************************************
// Register file layout, word indices and the last halfword index
// ****************************************************************
`define RF_WORDS            48
`define RF_BASE_FIRST       6'h00
`define RF_ARITH_FIRST      6'h10
`define RF_IDXVEC_FIRST     6'h20
`define RF_WORD_LAST        16'h002f
`define RF_PAIR_LAST        16'h002e
`define RF_HALF_LAST        16'h005f

// ****************************************************************
// Bus offsets, byte addresses
// ****************************************************************
`define OFS_STATUS          12'h000
`define OFS_CTRL            12'h004
`define OFS_RF_FIRST        12'h100
`define OFS_RF_LAST         12'h1bc

// ****************************************************************
// Status and control fields
// ****************************************************************
`define ST_EQUAL_BIT        0
`define ST_GREATER_BIT      1
`define ST_LESS_BIT         2
`define ST_FIXED_OVF_BIT    3
`define ST_FLOAT_OVF_BIT    4
`define ST_FLOAT_UNF_BIT    5
`define ST_SPEC_ERR_BIT     6
`define CTRL_ENABLE_BIT     0
`define CTRL_RESET          1'b1
`define STATUS_RESET        7'h00

// ****************************************************************
// Special values
// ****************************************************************
`define WORD_MOST_NEG       32'h80000000
`define HALF_MOST_NEG       16'h8000
`define FLT_EXP_MAX         9'sd127

`endif

//--- logic/add_instruction_execute.v
// Add instruction execution datapath with its register file and a Wishbone slave.
// Assumes the front end presents one decoded add on a clk_i edge with op_valid_i,
// with memory operands already fetched, all on the same clock.
//
// Summary of operation
// - Word add: arithmetic register plus 32-bit operand, sum back to it.
// - Memory operand comes from central memory or the register file alike.
// - Base add: base register plus word operand, sum into that base register.
// - Index/vector add: field 0-7 picks index, 8-F picks vector register.
// - Result code from stored result: negative 100, positive 010, zero 001.
// - Word, immediate and halfword adds flag fixed-point overflow on signed overflow.
// - Immediate adds target arithmetic, base or index/vector register likewise.
// - Halfword add: 16-bit operand into left half of register only.
// - Halfword address up to 5F with M zero reads one of 96 halfword registers.
// - Halfword immediate is M&N, M top bit is sign, plus index when selected.
// - Float word add into arithmetic register, flags float overflow or underflow.
// - Double float add: pair R,R+1 plus memory pair, low part in R+1.
// - Double float add with odd register field raises specification error.
// - Magnitude add: absolute value of word added to arithmetic register.
// - Most negative operand added unchanged; overflow only if register not negative.
// - Magnitude add also overflows when positive register sum leaves range.
// - Halfword magnitude add into left half, same most-negative cases at 16 bits.
// - Halfword magnitude result code comes from the 16-bit result.
// - Float magnitude add: absolute float operand added to arithmetic register.
// - Magnitude of negative fixed operand is its two's complement.
// - Word immediate is sign-extended into the upper half before adding.
`include "add_exec_defines.vh"

module add_instruction_execute #(
    parameter RF_N = `RF_WORDS
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        op_valid_i,
    input  wire [7:0]  op_code_i,
    input  wire [3:0]  op_r_i,
    input  wire [2:0]  op_x_i,
    input  wire [3:0]  op_m_i,
    input  wire [15:0] op_addr_i,
    input  wire [15:0] op_imm_i,
    input  wire [31:0] mem_word_i,
    input  wire [31:0] mem_word_next_i,
    input  wire [15:0] mem_half_i,
    output reg         op_ready_o,
    output reg         done_o,
    output reg  [31:0] result_o,
    output reg         result_less_bit_o,
    output reg         result_greater_bit_o,
    output reg         result_equal_bit_o,
    output reg         fixed_ovf_o,
    output reg         float_ovf_o,
    output reg         float_unf_o,
    output reg         spec_err_o,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [11:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    reg  [31:0] rf_q [0:RF_N-1];
    reg  [6:0]  status_q;
    reg         ctrl_q;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire        go       = op_valid_i & ctrl_q;
    wire        is_half  = (op_code_i == `OPC_ADD_HALF) | (op_code_i == `OPC_ADD_MAG_HALF) |
                           (op_code_i == `OPC_ADD_IMM_HALF);
    wire        is_mag   = (op_code_i == `OPC_ADD_MAG_WORD) | (op_code_i == `OPC_ADD_MAG_HALF);
    wire        is_fsgl  = (op_code_i == `OPC_ADD_FLOAT_WORD) | (op_code_i == `OPC_ADD_MAG_FLOAT);
    wire        is_fdbl  = (op_code_i == `OPC_ADD_FLOAT_DBL);
    wire        is_imm   = (op_code_i == `OPC_ADD_IMM_WORD) | (op_code_i == `OPC_ADD_IMM_BASE) |
                           (op_code_i == `OPC_ADD_IMM_IDXVEC) | (op_code_i == `OPC_ADD_IMM_HALF);
    wire        known    = is_half | is_mag | is_fsgl | is_fdbl | is_imm |
                           (op_code_i == `OPC_ADD_WORD) | (op_code_i == `OPC_ADD_BASE) |
                           (op_code_i == `OPC_ADD_IDXVEC);
    wire        spec_bad = is_fdbl & op_r_i[0];
    reg  [5:0]  dst;

    always @* begin
        case (op_code_i)
            `OPC_ADD_BASE, `OPC_ADD_IMM_BASE:     dst = `RF_BASE_FIRST + {2'b00, op_r_i};
            `OPC_ADD_IDXVEC, `OPC_ADD_IMM_IDXVEC: dst = `RF_IDXVEC_FIRST + {2'b00, op_r_i};
            default:                              dst = `RF_ARITH_FIRST + {2'b00, op_r_i};
        endcase
    end

    wire [5:0]  dst_lo   = {dst[5:1], 1'b1};
    wire [31:0] reg_a    = rf_q[dst];
    wire [31:0] reg_a_lo = rf_q[dst_lo];

    // ****************************************************************
    // Operand fetch
    // ****************************************************************
    wire        m_zero   = (op_m_i == 4'h0);
    wire        w_in_rf  = m_zero & (op_addr_i <= `RF_WORD_LAST);
    wire        d_in_rf  = m_zero & (op_addr_i <= `RF_PAIR_LAST);
    wire        h_in_rf  = m_zero & (op_addr_i <= `RF_HALF_LAST);
    wire [31:0] rf_word  = rf_q[op_addr_i[5:0]];
    wire [31:0] rf_next  = rf_q[op_addr_i[5:0] + 6'h01];
    wire [31:0] rf_hword = rf_q[op_addr_i[6:1]];
    wire [15:0] rf_half  = op_addr_i[0] ? rf_hword[15:0] : rf_hword[31:16];
    wire [31:0] opnd_w   = w_in_rf ? rf_word : mem_word_i;
    wire [31:0] opnd_w2  = d_in_rf ? rf_next : mem_word_next_i;
    wire [15:0] opnd_h   = h_in_rf ? rf_half : mem_half_i;
    wire [31:0] idx_val  = (op_x_i == 3'h0) ? 32'h00000000 : rf_q[`RF_IDXVEC_FIRST + {3'b000, op_x_i}];
    wire [31:0] imm_w    = {{16{op_imm_i[15]}}, op_imm_i} + idx_val;
    wire [15:0] imm_h    = op_imm_i + idx_val[15:0];

    // ****************************************************************
    // Fixed-point add, word and halfword
    // ****************************************************************
    reg  [31:0] fx_b;
    reg  [31:0] fx_a;
    reg  [31:0] fx_sum;
    reg         fx_ovf;
    reg         most_neg;

    always @* begin
        fx_a     = is_half ? {reg_a[31:16], 16'h0000} : reg_a;
        if (is_half)
            fx_b = {(is_imm ? imm_h : opnd_h), 16'h0000};
        else
            fx_b = is_imm ? imm_w : opnd_w;
        most_neg = (fx_b == `WORD_MOST_NEG);
        if (is_mag & fx_b[31])
            fx_b = 32'h00000000 - fx_b;
        fx_sum   = fx_a + fx_b;
        if (is_mag & most_neg)
            fx_ovf = ~fx_a[31];
        else
            fx_ovf = (fx_a[31] == fx_b[31]) & (fx_sum[31] != fx_a[31]);
    end

    // ****************************************************************
    // Floating add, hexadecimal format, 56-bit fraction datapath
    // ****************************************************************
    reg         sa, sb, sbig, ssml, fl_sign;
    reg  [6:0]  ea, eb, ebig, ediff;
    reg  [55:0] fa, fb, fbig, fsml, fres;
    reg  [56:0] fsum;
    reg  signed [8:0] eres;
    reg         a_big, fl_ovf, fl_unf;
    reg  [31:0] fl_hi, fl_lo, fb_hi;
    integer     k;

    always @* begin
        fb_hi = (op_code_i == `OPC_ADD_MAG_FLOAT) ? {1'b0, opnd_w[30:0]} : opnd_w;
        sa    = reg_a[31];
        ea    = reg_a[30:24];
        sb    = fb_hi[31];
        eb    = fb_hi[30:24];
        fa    = {reg_a[23:0], (is_fdbl ? reg_a_lo : 32'h00000000)};
        fb    = {fb_hi[23:0], (is_fdbl ? opnd_w2 : 32'h00000000)};
        if (fa == 56'h0)
            a_big = 1'b0;
        else if (fb == 56'h0)
            a_big = 1'b1;
        else
            a_big = (ea > eb) | ((ea == eb) & (fa >= fb));
        sbig  = a_big ? sa : sb;
        ssml  = a_big ? sb : sa;
        ebig  = a_big ? ea : eb;
        fbig  = a_big ? fa : fb;
        fsml  = a_big ? fb : fa;
        ediff = ebig - (a_big ? eb : ea);
        if (ediff > 7'd13)
            fsml = 56'h0;
        else
            fsml = fsml >> {ediff, 2'b00};
        if (sbig == ssml)
            fsum = {1'b0, fbig} + {1'b0, fsml};
        else
            fsum = {1'b0, fbig} - {1'b0, fsml};
        eres = {2'b00, ebig};
        if (fsum[56]) begin
            fres = {3'b000, fsum[56:4]};
            eres = eres + 9'sd1;
        end else begin
            fres = fsum[55:0];
        end
        for (k = 0; k < 14; k = k + 1) begin
            if ((fres != 56'h0) && (fres[55:52] == 4'h0)) begin
                fres = fres << 4;
                eres = eres - 9'sd1;
            end
        end
        fl_sign = (fres != 56'h0) & sbig;
        fl_ovf  = (fres != 56'h0) & (eres > `FLT_EXP_MAX);
        fl_unf  = (fres != 56'h0) & (eres < 9'sd0);
        if ((fres == 56'h0) | fl_unf) begin
            fl_hi = 32'h00000000;
            fl_lo = 32'h00000000;
        end else begin
            fl_hi = {fl_sign, eres[6:0], fres[55:32]};
            fl_lo = fres[31:0];
        end
    end

    // ****************************************************************
    // Result selection and result code
    // ****************************************************************
    reg  [31:0] res;
    reg         res_neg, res_zero;

    always @* begin
        if (is_fsgl | is_fdbl)
            res = fl_hi;
        else if (is_half)
            res = {fx_sum[31:16], reg_a[15:0]};
        else
            res = fx_sum;
        if (is_half) begin
            res_neg  = fx_sum[31];
            res_zero = (fx_sum[31:16] == 16'h0000);
        end else if (is_fdbl) begin
            res_neg  = fl_hi[31];
            res_zero = ({fl_hi[23:0], fl_lo} == 56'h0);
        end else if (is_fsgl) begin
            res_neg  = fl_hi[31];
            res_zero = (fl_hi[23:0] == 24'h0);
        end else begin
            res_neg  = fx_sum[31];
            res_zero = (fx_sum == 32'h00000000);
        end
    end

    wire        exec     = go & known & ~spec_bad;
    wire        set_fx   = exec & ~(is_fsgl | is_fdbl) & fx_ovf;
    wire        set_fo   = exec & (is_fsgl | is_fdbl) & fl_ovf;
    wire        set_fu   = exec & (is_fsgl | is_fdbl) & fl_unf;
    wire        set_sp   = go & spec_bad;

    // ****************************************************************
    // Wishbone slave decode
    // ****************************************************************
    wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wb_is_rf = (wb_adr_i >= `OFS_RF_FIRST) & (wb_adr_i <= `OFS_RF_LAST);
    wire [11:0] wb_rofs  = wb_adr_i - `OFS_RF_FIRST;
    wire [5:0]  wb_idx   = wb_rofs[7:2];
    wire [31:0] wb_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wb_old   = rf_q[wb_idx];
    wire [31:0] wb_merge = (wb_old & ~wb_mask) | (wb_dat_i & wb_mask);
    wire        wb_wr    = wb_req & wb_we_i;
    wire        st_clr   = wb_wr & (wb_adr_i == `OFS_STATUS) & wb_sel_i[0];
    reg  [31:0] wb_rd;

    always @* begin
        wb_rd = 32'h00000000;
        if (wb_adr_i == `OFS_STATUS)
            wb_rd = {25'h0000000, status_q};
        else if (wb_adr_i == `OFS_CTRL)
            wb_rd = {31'h00000000, ctrl_q};
        else if (wb_is_rf)
            wb_rd = wb_old;
    end

    // ****************************************************************
    // State update
    // ****************************************************************
    integer i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < RF_N; i = i + 1)
                rf_q[i] <= 32'h00000000;
            status_q             <= `STATUS_RESET;
            ctrl_q               <= `CTRL_RESET;
            op_ready_o           <= 1'b0;
            done_o               <= 1'b0;
            result_o             <= 32'h00000000;
            result_less_bit_o    <= 1'b0;
            result_greater_bit_o <= 1'b0;
            result_equal_bit_o   <= 1'b0;
            fixed_ovf_o          <= 1'b0;
            float_ovf_o          <= 1'b0;
            float_unf_o          <= 1'b0;
            spec_err_o           <= 1'b0;
            wb_dat_o             <= 32'h00000000;
            wb_ack_o             <= 1'b0;
        end else begin
            wb_ack_o    <= wb_req;
            wb_dat_o    <= wb_req ? wb_rd : 32'h00000000;
            op_ready_o  <= ctrl_q;
            if (wb_wr & wb_is_rf)
                rf_q[wb_idx] <= wb_merge;
            if (wb_wr & (wb_adr_i == `OFS_CTRL) & wb_sel_i[0])
                ctrl_q <= wb_dat_i[`CTRL_ENABLE_BIT];
            // Write one clears a sticky flag; a new event in the same cycle wins.
            status_q[`ST_FIXED_OVF_BIT] <= set_fx | (status_q[`ST_FIXED_OVF_BIT] &
                                           ~(st_clr & wb_dat_i[`ST_FIXED_OVF_BIT]));
            status_q[`ST_FLOAT_OVF_BIT] <= set_fo | (status_q[`ST_FLOAT_OVF_BIT] &
                                           ~(st_clr & wb_dat_i[`ST_FLOAT_OVF_BIT]));
            status_q[`ST_FLOAT_UNF_BIT] <= set_fu | (status_q[`ST_FLOAT_UNF_BIT] &
                                           ~(st_clr & wb_dat_i[`ST_FLOAT_UNF_BIT]));
            status_q[`ST_SPEC_ERR_BIT]  <= set_sp | (status_q[`ST_SPEC_ERR_BIT] &
                                           ~(st_clr & wb_dat_i[`ST_SPEC_ERR_BIT]));
            done_o      <= go & known;
            fixed_ovf_o <= set_fx;
            float_ovf_o <= set_fo;
            float_unf_o <= set_fu;
            spec_err_o  <= set_sp;
            if (exec) begin
                rf_q[dst]                    <= res;
                if (is_fdbl)
                    rf_q[dst_lo]             <= fl_lo;
                result_o                     <= res;
                result_less_bit_o            <= res_neg & ~res_zero;
                result_greater_bit_o         <= ~res_neg & ~res_zero;
                result_equal_bit_o           <= res_zero;
                status_q[`ST_LESS_BIT]       <= res_neg & ~res_zero;
                status_q[`ST_GREATER_BIT]    <= ~res_neg & ~res_zero;
                status_q[`ST_EQUAL_BIT]      <= res_zero;
            end
        end
    end

endmodule

//--- tb/add_front_end_model.sv
// Front-end model: central memory words and halfwords presented by operand address.
// Assumes the bench drives address and valid; contents are a fixed pattern.
// ****
// Operand source
// ****
module add_front_end_model (
    input  wire         op_valid_i,
    input  wire  [15:0] op_addr_i,
    output logic [31:0] mem_word_o,
    output logic [31:0] mem_word_next_o,
    output logic [15:0] mem_half_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:255];
    logic [31:0] fill;
    wire  [31:0] hw   = mem[op_addr_i[8:1]];
    wire  [31:0] flip = {32{~op_valid_i}};
    initial begin
        fill = 32'hb635;
        for (int i = 0; i < 256; i++) begin
            mem[i] = fill;
            fill = fill * 32'h0019660d + 32'h3c6ef35f;
        end
        mem[252] = 32'h80008000;
        mem[253] = 32'h80000000;
        mem[254] = 32'h42123456;
        mem[255] = 32'hc1100000;
    end
    // Lines not qualified by valid show a changed pattern, never the held value.
    assign mem_word_o      = mem[op_addr_i[7:0]] ^ flip;
    assign mem_word_next_o = mem[op_addr_i[7:0] + 8'h01] ^ flip;
    assign mem_half_o      = (op_addr_i[0] ? hw[15:0] : hw[31:16]) ^ flip[15:0];
endmodule

//--- tb/add_exec_sva.sv
// Concurrent checks on the ports of the add execution datapath.
// Assumes it is bound into add_instruction_execute on its single clock.
// ****
// Checker
// ****
module add_exec_sva #(
    parameter RF_N = 48
) (
    input wire        clk_i,
    input wire        rst_i,
    input wire        op_valid_i,
    input wire [7:0]  op_code_i,
    input wire [3:0]  op_r_i,
    input wire [3:0]  op_m_i,
    input wire [31:0] mem_word_i,
    input wire        op_ready_o,
    input wire        done_o,
    input wire [31:0] result_o,
    input wire        result_less_bit_o,
    input wire        result_greater_bit_o,
    input wire        result_equal_bit_o,
    input wire        fixed_ovf_o,
    input wire        spec_err_o
);
    timeunit 1ns;
    timeprecision 1ns;
    wire known  = op_code_i inside {8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46,
                                    8'h50, 8'h51, 8'h60, 8'h62, 8'h70, 8'h72};
    wire is_half = op_code_i inside {8'h41, 8'h45, 8'h51};
    wire is_flt  = op_code_i inside {8'h42, 8'h43, 8'h46};
    wire r_odd   = op_r_i[0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence taken_s;
        op_valid_i && op_ready_o && known;
    endsequence
    sequence spec_s;
        taken_s ##0 (op_code_i == 8'h43 && r_odd);
    endsequence
    sequence mag_neg_s;
        taken_s ##0 (op_code_i == 8'h44 && op_m_i != 4'h0 && mem_word_i == 32'h80000000);
    endsequence
    done_follow_a: assert property (taken_s |=> done_o)
        else $error("no done after an accepted add");
    spec_raise_a: assert property (spec_s |=> spec_err_o && done_o)
        else $error("odd pair register gave no specification error");
    spec_keep_a: assert property (spec_err_o |-> $stable(result_o) && $stable(result_less_bit_o))
        else $error("specification error changed the result");
    code_word_a: assert property (done_o && !$past(is_half) && !$past(is_flt) |->
        result_less_bit_o == result_o[31] && result_equal_bit_o == (result_o == 32'h0))
        else $error("word result code does not match result");
    code_half_a: assert property (done_o && $past(is_half) |->
        result_less_bit_o == result_o[31] && result_equal_bit_o == (result_o[31:16] == 16'h0))
        else $error("halfword result code does not match left half");
    code_hold_a: assert property (!done_o |-> $stable(result_greater_bit_o) && $stable(result_equal_bit_o))
        else $error("result code moved without a completed add");
    fixed_kind_a: assert property (fixed_ovf_o |-> done_o && !$past(is_flt))
        else $error("fixed overflow outside a fixed-point add");
    mag_neg_a: assert property (mag_neg_s |=> fixed_ovf_o == result_o[31])
        else $error("most negative magnitude operand overflow wrong");
endmodule
bind add_instruction_execute add_exec_sva #(.RF_N(RF_N)) add_exec_sva_inst (.*);

//--- tb/add_instruction_execute_bench.sv
// Self-checking bench for the add execution datapath.
// Assumes the front-end model and the checker are compiled before it.
// ****
// Bench
// ****
module add_instruction_execute_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i, op_valid_i, wb_cyc_i, wb_stb_i, wb_we_i, op_ready_o, done_o, wb_ack_o;
    logic        result_less_bit_o, result_greater_bit_o, result_equal_bit_o;
    logic        fixed_ovf_o, float_ovf_o, float_unf_o, spec_err_o;
    logic [7:0]  op_code_i;
    logic [3:0]  op_r_i, op_m_i, wb_sel_i;
    logic [2:0]  op_x_i;
    logic [15:0] op_addr_i, op_imm_i, mem_half_i;
    logic [11:0] wb_adr_i;
    logic [31:0] mem_word_i, mem_word_next_i, wb_dat_i, wb_dat_o, result_o;
    logic [31:0] rf [0:47];
    logic [31:0] seed = 32'hb635;
    logic [7:0]  ops [0:9] = '{8'h40, 8'h41, 8'h44, 8'h45, 8'h50, 8'h51, 8'h60, 8'h62, 8'h70, 8'h72};
    int          failures = 0;
    int          n_checks = 0;
    int          cycles = 0;
    add_instruction_execute add_instruction_execute_inst (.*);
    add_front_end_model fe (.op_valid_i(op_valid_i), .op_addr_i(op_addr_i), .mem_word_o(mem_word_i),
                            .mem_word_next_o(mem_word_next_i), .mem_half_o(mem_half_i));
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            conclude();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic conclude();
        if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic put(input int i, input logic [31:0] v);
        logic [31:0] q;
        wb(1'b1, 12'h100 + 12'(i * 4), v, q);
        rf[i] = v;
    endtask
    task automatic issue(input logic [7:0] op, input logic [3:0] r, input logic [2:0] x,
                         input logic [3:0] m, input logic [15:0] a, input logic [15:0] imm);
        @(posedge clk_i);
        op_valid_i <= 1'b1;
        op_code_i  <= op;
        op_r_i     <= r;
        op_x_i     <= x;
        op_m_i     <= m;
        op_addr_i  <= a;
        op_imm_i   <= imm;
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        @(negedge clk_i);
    endtask
    function automatic logic [33:0] expect_add(input logic [7:0] op, input int d, input logic [2:0] x,
        input logic [3:0] m, input logic [15:0] a, input logic [15:0] imm);
        logic [31:0] w, s, hw, idx;
        logic [15:0] h;
        logic        ov, hf, z;
        idx = (x == 3'h0) ? 32'h0 : rf[32 + x];
        w = (m == 4'h0 && a <= 16'h2f) ? rf[a] : fe.mem[a[7:0]];
        hw = (m == 4'h0 && a <= 16'h5f) ? rf[a[6:1]] : fe.mem[a[8:1]];
        h = a[0] ? hw[15:0] : hw[31:16];
        hf = op == 8'h41 || op == 8'h45 || op == 8'h51;
        if (op[4]) w = {{16{imm[15]}}, imm} + idx;
        if (op == 8'h51) h = imm + idx[15:0];
        if (op == 8'h44 && w != 32'h80000000 && w[31]) w = -w;
        if (op == 8'h45 && h != 16'h8000 && h[15]) h = -h;
        s = hf ? {rf[d][31:16] + h, rf[d][15:0]} : rf[d] + w;
        ov = hf ? (rf[d][31] == h[15] && s[31] != h[15]) : (rf[d][31] == w[31] && s[31] != w[31]);
        if ((op == 8'h44 && w == 32'h80000000) || (op == 8'h45 && h == 16'h8000)) ov = !rf[d][31];
        z = hf ? s[31:16] == 16'h0 : s == 32'h0;
        return {z, ov, s};
    endfunction
    task automatic run(input logic [7:0] op, input logic [3:0] r, input logic [2:0] x,
                       input logic [3:0] m, input logic [15:0] a, input logic [15:0] imm, input logic take);
        logic [31:0] s, q;
        logic        ov, z;
        int          d;
        d = (op[5] ? (op[1] ? 32 : 0) : 16) + r;
        {z, ov, s} = expect_add(op, d, x, m, a, imm);
        issue(op, r, x, m, a, imm);
        chk("done", done_o, take);
        if (take) begin
            chk("result", result_o, s);
            chk("code", {result_less_bit_o, result_greater_bit_o, result_equal_bit_o},
                {s[31], !s[31] && !z, z});
            chk("overflow", fixed_ovf_o, ov);
            rf[d] = s;
        end
        wb(1'b0, 12'h100 + 12'(d * 4), 32'h0, q);
        chk("register", q, rf[d]);
    endtask
    initial begin
        logic [31:0] v, q;
        {op_valid_i, wb_cyc_i, wb_stb_i, wb_we_i, op_code_i, op_r_i, op_m_i, op_x_i} = '0;
        {op_addr_i, op_imm_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk("ready", op_ready_o, 1'b1);
        for (int i = 0; i < 48; i++) put(i, rnd());
        put(19, 32'h5);
        run(8'h44, 4'h3, 3'h0, 4'h1, 16'h00fd, 16'h0, 1'b1);
        put(20, 32'hf0000000);
        run(8'h44, 4'h4, 3'h0, 4'h1, 16'h00fd, 16'h0, 1'b1);
        put(21, 32'h0);
        run(8'h45, 4'h5, 3'h0, 4'h1, 16'h01f8, 16'h0, 1'b1);
        put(22, 32'h7fff0000);
        run(8'h51, 4'h6, 3'h0, 4'h0, 16'h0, 16'h0001, 1'b1);
        run(8'h50, 4'h7, 3'h0, 4'h0, 16'h0, 16'hffff, 1'b1);
        run(8'h40, 4'h1, 3'h0, 4'h0, 16'h002f, 16'h0, 1'b1);
        run(8'h40, 4'h2, 3'h0, 4'h0, 16'h0030, 16'h0, 1'b1);
        run(8'h41, 4'h3, 3'h0, 4'h0, 16'h005f, 16'h0, 1'b1);
        run(8'h41, 4'h3, 3'h0, 4'h0, 16'h0060, 16'h0, 1'b1);
        run(8'h62, 4'hf, 3'h0, 4'h0, 16'h0005, 16'h0, 1'b1);
        run(8'h72, 4'h8, 3'h7, 4'h0, 16'h0, 16'h8000, 1'b1);
        for (int i = 0; i < 300; i++) begin
            v = rnd();
            run(ops[v[3:0] % 10], v[7:4], ops[v[3:0] % 10][4] ? v[10:8] : 3'h0,
                v[11] ? 4'h0 : v[15:12], {7'h0, v[24:16]}, v[31:16], 1'b1);
        end
        run(8'h48, 4'h1, 3'h0, 4'h1, 16'h0010, 16'h0, 1'b0);
        wb(1'b1, 12'h004, 32'h0, q);
        run(8'h40, 4'h1, 3'h0, 4'h1, 16'h0010, 16'h0, 1'b0);
        wb(1'b1, 12'h004, 32'h1, q);
        wb(1'b0, 12'hffc, 32'h0, q);
        chk("unmapped", q, 32'h0);
        put(31, 32'h0);
        issue(8'h42, 4'hf, 3'h0, 4'h1, 16'h00ff, 16'h0);
        chk("float", {result_less_bit_o, result_o}, {1'b1, 32'hc1100000});
        put(31, 32'h0);
        issue(8'h46, 4'hf, 3'h0, 4'h1, 16'h00ff, 16'h0);
        chk("magnitude", {result_greater_bit_o, result_o}, {1'b1, 32'h41100000});
        put(31, 32'h7ff00000);
        issue(8'h42, 4'hf, 3'h0, 4'h0, 16'h001f, 16'h0);
        chk("f_ovf", {float_ovf_o, result_o}, {1'b1, 32'h001e0000});
        put(30, 32'h80100000);
        issue(8'h42, 4'hf, 3'h0, 4'h0, 16'h001e, 16'h0);
        chk("f_unf", {float_unf_o, result_equal_bit_o, result_o}, {2'b11, 32'h0});
        put(18, 32'h0);
        put(19, 32'h0);
        issue(8'h43, 4'h2, 3'h0, 4'h1, 16'h00fe, 16'h0);
        chk("double", {done_o, result_o}, {1'b1, 32'h42123456});
        wb(1'b0, 12'h14c, 32'h0, q);
        chk("low", q, 32'hc1100000);
        v = result_o;
        issue(8'h43, 4'h3, 3'h0, 4'h1, 16'h00fe, 16'h0);
        chk("spec", {done_o, spec_err_o, result_o}, {2'b11, v});
        wb(1'b0, 12'h000, 32'h0, q);
        chk("status", q[6], 1'b1);
        conclude();
    end
endmodule
